// file: subdp_map.vh
/*
 header of constants for the subtract datapath: instruction encodings,
 field positions, phase codes and reset values.
 assumes a 14-bit instruction word and an 8-bit data path.
*/
`ifndef SUBDP_MAP_VH
`define SUBDP_MAP_VH

// ----------------------------------------
// instruction fields
// ----------------------------------------
`define SUBDP_LIT_OPC_MSB   13
`define SUBDP_LIT_OPC_LSB   9
`define SUBDP_LIT_OPC       5'h1e
`define SUBDP_FILE_OPC_MSB  13
`define SUBDP_FILE_OPC_LSB  8
`define SUBDP_FILE_OPC      6'h02
`define SUBDP_DEST_BIT      7
`define SUBDP_ADDR_MSB      6
`define SUBDP_LIT_MSB       7

// ----------------------------------------
// phase codes within one instruction cycle
// ----------------------------------------
`define SUBDP_PH_DECODE     2'h0
`define SUBDP_PH_READ       2'h1
`define SUBDP_PH_PROCESS    2'h2
`define SUBDP_PH_WRITE      2'h3

// ----------------------------------------
// reset values
// ----------------------------------------
`define SUBDP_ACC_RST       8'h00
`define SUBDP_FLAG_RST      1'b0

`endif

// file: subdp_file_ram.v
/*
 small data-memory file of 8-bit registers, one write and one read port.
 read data come out of a register one clock after the address.
*/
`timescale 1ns/10ps

module subdp_file_ram #(
   parameter AW = 7,
   parameter DW = 8
) (
   // clock
   input  wire          mclk,
   // write port
   input  wire          wr_en,
   input  wire [AW-1:0] wr_addr,
   input  wire [DW-1:0] wr_data,
   // read port
   input  wire [AW-1:0] rd_addr,
   output reg  [DW-1:0] rd_data
);

   reg [DW-1:0] mem [0:(1<<AW)-1];
   integer      i;

   // power-up contents are zero; reset leaves the file alone, so a value
   // written back survives a core reset
   initial begin
      for (i = 0; i < (1 << AW); i = i + 1) begin
         mem[i] = {DW{1'b0}};
      end
   end

   always @(posedge mclk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end

endmodule // subdp_file_ram

// file: subdp_top.v
/*
 execution datapath for the two subtract instructions: literal minus
 accumulator, and file register minus accumulator with selectable destination.
 assumes the core presents an instruction word with issue pulse, one
 instruction at a time, each taking four clocks (one per phase).
*/
`timescale 1ns/10ps
`include "subdp_map.vh"

//
// Contract
// (RULE_01) The literal subtract puts the low eight instruction bits minus the accumulator into the accumulator.
// (RULE_02) The file subtract computes the file register at the 7-bit instruction address minus the accumulator.
// (RULE_03) A destination bit of 0 sends the difference to the accumulator, 1 back to the file register.
// (RULE_04) Carry is 1 when no borrow occurs (result zero or positive) and 0 when it is negative.
// (RULE_05) Each subtract takes one word and one cycle of four phases: decode, read, process, write.
// (RULE_06) Zero flag follows an all-zero difference and digit carry is set when the low nibble does not borrow.
//
module subdp_top #(
   parameter AW = 7,
   parameter DW = 8
) (
   // clock and reset
   input  wire          mclk,
   input  wire          sys_rst,
   // instruction issue
   input  wire          instr_valid,
   input  wire [13:0]   instr_word,
   // state and status
   output reg  [DW-1:0] acc,
   output reg           carry_flag,
   output reg           digit_carry_flag,
   output reg           zero_flag,
   output reg           busy,
   output reg           done,
   output reg           illegal
);

   // ----------------------------------------
   // decode helpers
   // ----------------------------------------
   function is_lit;
      input [13:0] w;
      begin
         is_lit = (w[`SUBDP_LIT_OPC_MSB:`SUBDP_LIT_OPC_LSB] == `SUBDP_LIT_OPC);
      end
   endfunction

   function is_file;
      input [13:0] w;
      begin
         is_file = (w[`SUBDP_FILE_OPC_MSB:`SUBDP_FILE_OPC_LSB] == `SUBDP_FILE_OPC);
      end
   endfunction

   // literal form and d=0 land in the accumulator, d=1 in the file
   function to_acc;
      input        lit;
      input [13:0] w;
      begin
         to_acc = lit || !w[`SUBDP_DEST_BIT];                           // RULE_03
      end
   endfunction

   function is_zero;
      input [DW-1:0] v;
      begin
         is_zero = (v == {DW{1'b0}});
      end
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   reg  [1:0]    phase;
   reg  [13:0]   instr;
   reg           op_lit;
   reg  [DW-1:0] opnd;
   // digit carry comes out of the low nibble
   localparam NIB_W = 4;
   wire [DW-1:0] ram_q;
   wire          file_wr;
   wire [AW-1:0] file_addr;
   wire [DW-1:0] diff;
   wire [DW:0]   chain;
   wire          no_borrow;
   wire          nib_no_borrow;
   wire          retire;
   wire          take;
   wire          word_lit;
   wire          word_file;
   wire          take_sub;
   wire          take_bad;

   // ----------------------------------------
   // issue decode
   // ----------------------------------------
   assign take      = instr_valid && !busy;
   assign word_lit  = is_lit(instr_word);
   assign word_file = is_file(instr_word);
   assign take_sub  = take && (word_lit || word_file);                 // RULE_01 RULE_02
   assign take_bad  = take && !(word_lit || word_file);

   // ----------------------------------------
   // ripple subtractor
   // ----------------------------------------
   // a - b is built as a + ~b + 1, so each carry is an inverted borrow;
   // a ripple chain exposes the nibble carry without a second adder
   assign chain[0] = 1'b1;

   genvar gi;
   generate
      for (gi = 0; gi < DW; gi = gi + 1) begin : g_bit
         wire b_inv;
         assign b_inv         = ~acc[gi];
         assign diff[gi]      = opnd[gi] ^ b_inv ^ chain[gi];
         assign chain[gi + 1] = (opnd[gi] & b_inv) | (chain[gi] & (opnd[gi] ^ b_inv));
      end
   endgenerate

   assign no_borrow     = chain[DW];                                    // RULE_04
   assign nib_no_borrow = chain[NIB_W];                                 // RULE_06
   assign retire        = busy && (phase == `SUBDP_PH_WRITE);          // RULE_05

   assign file_addr = instr[AW-1:0];                                   // RULE_02
   assign file_wr   = retire && !to_acc(op_lit, instr);                // RULE_03

   subdp_file_ram #(
      .AW (AW),
      .DW (DW)
   ) u_ram (
      .mclk    (mclk),
      .wr_en   (file_wr),
      .wr_addr (file_addr),
      .wr_data (diff),
      .rd_addr (file_addr),
      .rd_data (ram_q)
   );

   // ----------------------------------------
   // four-phase sequencer
   // ----------------------------------------
   // a word is taken only while idle; one offered while busy is dropped
   // without any sign, which the issuing core must allow for
   always @(posedge mclk) begin
      if (sys_rst) begin
         phase   <= `SUBDP_PH_DECODE;
         instr   <= 14'h0000;
         op_lit  <= 1'b0;
         busy    <= 1'b0;
         done    <= 1'b0;
         illegal <= 1'b0;
      end else begin
         done    <= 1'b0;
         illegal <= 1'b0;
         if (!busy) begin
            if (take_sub) begin
               instr  <= instr_word;
               op_lit <= word_lit;
               busy   <= 1'b1;
               phase  <= `SUBDP_PH_READ;                                // RULE_05
            end else if (take_bad) begin
               illegal <= 1'b1;
            end
         end else begin
            case (phase)
               `SUBDP_PH_READ: begin
                  // ram read data land one clock later, in the process phase
                  phase <= `SUBDP_PH_PROCESS;                           // RULE_05
               end
               `SUBDP_PH_PROCESS: begin
                  phase <= `SUBDP_PH_WRITE;                             // RULE_05
               end
               `SUBDP_PH_WRITE: begin
                  phase <= `SUBDP_PH_DECODE;
                  busy  <= 1'b0;
                  done  <= 1'b1;                                        // RULE_05
               end
               default: begin
                  phase <= `SUBDP_PH_DECODE;
                  busy  <= 1'b0;
               end
            endcase
         end
      end
   end

   // ----------------------------------------
   // operand stage
   // ----------------------------------------
   // staged in the process phase so the write phase sees a settled
   // subtractor input
   always @(posedge mclk) begin
      if (sys_rst) begin
         opnd <= `SUBDP_ACC_RST;
      end else if (busy && (phase == `SUBDP_PH_PROCESS)) begin
         if (op_lit) begin
            opnd <= instr[`SUBDP_LIT_MSB:0];                            // RULE_01
         end else begin
            opnd <= ram_q;                                              // RULE_02
         end
      end
   end

   // ----------------------------------------
   // retire stage
   // ----------------------------------------
   // flags and accumulator move only at the end of the write phase, so an
   // illegal word or a refused issue never disturbs them
   always @(posedge mclk) begin
      if (sys_rst) begin
         acc              <= `SUBDP_ACC_RST;
         carry_flag       <= `SUBDP_FLAG_RST;
         digit_carry_flag <= `SUBDP_FLAG_RST;
         zero_flag        <= `SUBDP_FLAG_RST;
      end else if (retire) begin
         carry_flag       <= no_borrow;                                 // RULE_04
         digit_carry_flag <= nib_no_borrow;                             // RULE_06
         zero_flag        <= is_zero(diff);                             // RULE_06
         if (to_acc(op_lit, instr)) begin
            acc <= diff;                                                // RULE_01 RULE_03
         end
      end
   end

endmodule // subdp_top

// file: subdp_top_asserts.sv
/* checker for subdp_top ports.
 assumes one mclk domain with synchronous active-high reset. */
`timescale 1ns/10ps
module subdp_chk (
   input wire       mclk,
   input wire       sys_rst,
   input wire       instr_valid,
   input wire [13:0] instr_word,
   input wire [7:0] acc,
   input wire       carry_flag,
   input wire       digit_carry_flag,
   input wire       zero_flag,
   input wire       busy,
   input wire       done,
   input wire       illegal
);
   // ---------------
   // decode helpers
   // ---------------
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   sequence take; instr_valid && !busy; endsequence
   sequence lit; take ##0 instr_word[13:9] == 5'h1e; endsequence
   sequence sub; take ##0 (instr_word[13:9] == 5'h1e || instr_word[13:8] == 6'h02); endsequence
   sequence file_back; take ##0 instr_word[13:7] == 7'h05; endsequence
   sequence bad; take ##0 !(instr_word[13:9] == 5'h1e || instr_word[13:8] == 6'h02); endsequence
   // ---------------
   // properties
   // ---------------
   four_phase_a: assert property (sub |=> busy[*3] ##1 (done && !busy))
      else $error("subtract did not finish in four phases");
   lit_diff_a: assert property (lit |-> ##4 acc == $past(instr_word[7:0], 4) - $past(acc, 4))
      else $error("literal difference wrong");
   carry_set_a: assert property (lit |-> ##4 carry_flag == ($past(instr_word[7:0], 4) >= $past(acc, 4)))
      else $error("carry wrong");
   nibble_carry_a: assert property (lit |-> ##4 digit_carry_flag == ($past(instr_word[3:0], 4) >= $past(acc[3:0], 4)))
      else $error("digit carry wrong");
   zero_flag_a: assert property (lit |-> ##4 zero_flag == ($past(instr_word[7:0], 4) == $past(acc, 4)))
      else $error("zero flag wrong");
   file_dest_a: assert property (file_back |-> ##4 done && acc == $past(acc, 4))
      else $error("file destination touched the accumulator");
   other_word_a: assert property (bad |=> illegal && !busy && $stable(acc))
      else $error("non-subtract word not refused");
   busy_refuse_a: assert property (busy && instr_valid |=> !illegal)
      else $error("word taken while busy");
endmodule // subdp_chk
bind subdp_top subdp_chk u_chk (.mclk(mclk), .sys_rst(sys_rst), .instr_valid(instr_valid),
   .instr_word(instr_word), .acc(acc), .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag),
   .zero_flag(zero_flag), .busy(busy), .done(done), .illegal(illegal));

// file: testbench.sv
/* testbench for subdp_top: literal table, then file, refusal, illegal, reset.
 assumes the checker is bound from its own file. */
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
   $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module testbench;
   logic        mclk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        instr_valid = 1'b0;
   logic [13:0] instr_word = 14'h0000;
   wire  [7:0]  acc;
   wire         carry_flag, digit_carry_flag, zero_flag, busy, done, illegal;
   wire  [10:0] got = {acc, carry_flag, digit_carry_flag, zero_flag};
   int          errors = 0;
   int          checked = 0;
   logic [24:0] rows [6];
   subdp_top u_dut (.mclk(mclk), .sys_rst(sys_rst), .instr_valid(instr_valid),
      .instr_word(instr_word), .acc(acc), .carry_flag(carry_flag),
      .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag), .busy(busy),
      .done(done), .illegal(illegal));
   initial forever #5 mclk = ~mclk;
   // ---------------
   // tasks
   // ---------------
   task automatic end_of_test();
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic issue(input logic [13:0] w);
      instr_valid = 1'b1;
      instr_word = w;
      @(negedge mclk);
      instr_valid = 1'b0;
   endtask
   // bounded, a lost done would otherwise hang the run
   task automatic wait_done();
      for (int i = 0; i < 8 && done !== 1'b1; i++) @(negedge mclk);
      if (done !== 1'b1) begin errors++; end_of_test(); end
   endtask
   // ---------------
   // sequence
   // ---------------
   initial begin
      rows = '{{14'h3c02, 11'h016}, {14'h3d01, 11'h7f8}, {14'h3cff, 11'h007},
               {14'h3d10, 11'h086}, {14'h3c23, 11'h09e}, {14'h3c08, 11'h7aa}};
      repeat (6) @(negedge mclk);
      sys_rst = 1'b0;
      foreach (rows[i]) begin
         issue(rows[i][24:11]);
         wait_done();
         `CHK(got, rows[i][10:0])
      end
      $display("literal table done");
      // file starts at zero: write back 0 - acc, then put that file value minus acc into acc
      issue(14'h02ff);
      wait_done();
      `CHK(got, 11'h7a8)
      issue(14'h027f);
      wait_done();
      `CHK(got, 11'h0b2)
      `CHK(busy, 1'b0)
      $display("file cases done");
      instr_valid = 1'b1;
      instr_word = 14'h3c00;
      @(negedge mclk);
      instr_word = 14'h3c55;
      @(negedge mclk);
      instr_valid = 1'b0;
      wait_done();
      `CHK(carry_flag, 1'b0)
      `CHK(digit_carry_flag, 1'b0)
      `CHK(acc, 8'hea)
      @(negedge mclk);
      `CHK({done, busy}, 2'b00)
      $display("refusal done");
      issue(14'h0000);
      `CHK({illegal, busy, done}, 3'b100)
      $display("illegal done");
      sys_rst = 1'b1;
      @(negedge mclk);
      `CHK({got, busy, done, illegal}, 14'h0000)
      sys_rst = 1'b0;
      issue(14'h3c05);
      wait_done();
      `CHK(got, 11'h02e)
      $display("reset done");
      end_of_test();
   end
endmodule // testbench
